// [cmt10_load.sv]
// External load on the timer output pin, counting level changes
`timescale 1ns/100ps
module cmt10_load (
  input wire logic hclk, // Sampling clock
  input wire logic hresetn, // Reset, active low
  input wire logic timer_output_pin, // Level seen by the load
  output logic [15:0] edge_count // Level changes seen
);
  logic last_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_r <= 1'b0;
      edge_count <= 16'h0000;
    end else begin
      last_r <= timer_output_pin;
      if (last_r != timer_output_pin) begin
        edge_count <= edge_count + 16'h0001;
      end
    end
  end
endmodule : cmt10_load

// [cmt10_monitor.sv]
// Port checker of the 10-bit compare match timer
`timescale 1ns/100ps
module cmt10_monitor (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Select
  input wire logic [7:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Ready in
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Ready out
  input wire logic hresp, // Response
  input wire logic timer_output_pin, // Pin
  input wire logic match_a_flag, // Flag A
  input wire logic match_p_flag // Flag P
);
  logic wv_q, rv_q, fw;
  logic [7:0] wa_q, c0_r, c1_r;
  logic [9:0] ca_r;
  logic [1:0] quiet_r, mode;
  assign mode = c1_r[7:6];
  assign fw = wv_q && wa_q == cmt10_pkg::ADDR_FLAGS;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wv_q <= 1'b0;
      rv_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wv_q <= hsel && hready && htrans == cmt10_pkg::HTRANS_NONSEQ && hwrite;
      rv_q <= hsel && hready && htrans == cmt10_pkg::HTRANS_NONSEQ && !hwrite;
      wa_q <= haddr;
    end
  end
  // Shadow of the control and compare A registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c0_r <= 8'h00;
      c1_r <= 8'h00;
      ca_r <= 10'h000;
    end else if (wv_q) begin
      case (wa_q)
        cmt10_pkg::ADDR_CTRL0: c0_r <= hwdata[7:0];
        cmt10_pkg::ADDR_CTRL1: c1_r <= hwdata[7:0];
        cmt10_pkg::ADDR_CMPA_LO: ca_r[7:0] <= hwdata[7:0];
        cmt10_pkg::ADDR_CMPA_HI: ca_r[9:8] <= hwdata[1:0];
        default: ;
      endcase
    end
  end
  // Cycles since the last configuration write, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet_r <= 2'h0;
    end else if (wv_q && !fw) begin
      quiet_r <= 2'h0;
    end else if (quiet_r != 2'h3) begin
      quiet_r <= quiet_r + 2'h1;
    end
  end
  property p_a_sticky; match_a_flag && !(fw && hwdata[0]) |=> match_a_flag; endproperty
  a_a_sticky: assert property (p_a_sticky) else $error("flag A lost");
  property p_p_sticky; match_p_flag && !(fw && hwdata[1]) |=> match_p_flag; endproperty
  a_p_sticky: assert property (p_p_sticky) else $error("flag P lost");
  property p_tmr_pin; mode == cmt10_pkg::MODE_TMR && quiet_r == 2'h3 |-> !timer_output_pin;
  endproperty
  a_tmr_pin: assert property (p_tmr_pin) else $error("pin driven in timer mode");
  property p_pin_src;
    mode == cmt10_pkg::MODE_CMP && quiet_r == 2'h3 && $changed(timer_output_pin)
      |-> match_a_flag;
  endproperty
  a_pin_src: assert property (p_pin_src) else $error("pin moved without A match");
  property p_init;
    $rose(c0_r[3]) && mode == cmt10_pkg::MODE_CMP |=> timer_output_pin == (c1_r[3] ^ c1_r[2]);
  endproperty
  a_init: assert property (p_init) else $error("pin not at initial level");
  property p_no_p; mode == cmt10_pkg::MODE_CMP && c1_r[0] && quiet_r == 2'h3
    |-> !$rose(match_p_flag); endproperty
  a_no_p: assert property (p_no_p) else $error("flag P raised with A clearing");
  property p_a_zero; ca_r == 10'h000 && mode[0] == mode[1] && quiet_r == 2'h3
    |-> !$rose(match_a_flag); endproperty
  a_a_zero: assert property (p_a_zero) else $error("flag A with compare A zero");
  property p_cnt_hi; rv_q && wa_q == cmt10_pkg::ADDR_CNT_HI |-> hrdata[31:2] == 30'h0;
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("count high bits not zero");
  property p_ca_hi; rv_q && wa_q == cmt10_pkg::ADDR_CMPA_HI |-> hrdata == {30'h0, ca_r[9:8]};
  endproperty
  a_ca_hi: assert property (p_ca_hi) else $error("compare A high readback");
  c_a: cover property ($rose(match_a_flag));
  c_p: cover property ($rose(match_p_flag));
  c_pin: cover property (mode == cmt10_pkg::MODE_CMP && $changed(timer_output_pin));
endmodule : cmt10_monitor

bind cmt10_timer cmt10_monitor i_cmt10_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .timer_output_pin(timer_output_pin), .match_a_flag(match_a_flag),
  .match_p_flag(match_p_flag));

// [cmt10_pkg.sv]
// Package: register map, field positions, reset values and modes of the 10-bit timer
package cmt10_pkg;
  // Register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
  localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
  localparam logic [7:0] ADDR_CMPA_HI = 8'h14;
  localparam logic [7:0] ADDR_FLAGS = 8'h18;
  // Control register zero fields
  localparam int CTRL0_ON_BIT = 3;
  localparam int CTRL0_CMPP_LSB = 0;
  // Control register one fields
  localparam int CTRL1_MODE_LSB = 6;
  localparam int CTRL1_ACT_LSB = 4;
  localparam int CTRL1_OIL_BIT = 3;
  localparam int CTRL1_INV_BIT = 2;
  localparam int CTRL1_SWAP_BIT = 1;
  localparam int CTRL1_CLR_BIT = 0;
  // Flag register fields (write one to clear)
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  // Reset values and counter maximum
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [9:0] CMPA_RST = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  // Operating modes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  // Pin actions in compare match output mode
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOG = 2'h3;
  // Pin functions in PWM mode
  localparam logic [1:0] PWM_INACT = 2'h0;
  localparam logic [1:0] PWM_ACT = 2'h1;
  localparam logic [1:0] PWM_RUN = 2'h2;
  localparam logic [1:0] PWM_PULSE = 2'h3;
  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : cmt10_pkg

// [cmt10_timer.sv]
// Top module: 10-bit compare match timer with AHB-Lite register slave
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
// Operation
// RQ1: Compare mode: initial level bit sets pin before first A match.
// RQ2: PWM and single pulse: initial level bit picks active level.
// RQ3: Single pulse: pin takes initial level when counter-on rises.
// RQ4: Invert bit one inverts the pin, zero passes it.
// RQ5: Timer/counter mode: initial level and invert have no pin effect.
// RQ6: Swap bit zero: P period, A duty; one: P duty, A period.
// RQ7: Clear select one clears on A match; zero on P match or overflow.
// RQ8: Overflow clears only with clear select zero and compare P zero.
// RQ9: Clear select ignored in PWM, single pulse and capture modes.
// RQ10: Counter readable as low byte and two high bits, read only.
// RQ11: Compare A held as low byte and two high bits, read/write.
// RQ12: Two-bit mode field; 00 selects compare match output.
// RQ13: Compare mode, clear select zero: both A and P flags raise.
// RQ14: Clear select one: only A flag raises, never P.
// RQ15: Software must not program compare A zero in compare mode.
// RQ16: Compare A zero: counter overflows at maximum, no A flag.
// RQ17: Compare mode: pin changes only on A match, never on P.
// RQ18: A match drives pin high, low, toggles, or no change.
// RQ19: Counter-on rising in compare mode loads pin initial level.
// RQ20: Mode codes: 01 capture, 10 PWM/pulse, 11 timer/counter.
// RQ21: Pin action codes: 00 none, 01 low, 10 high, 11 toggle.
// RQ22: Counter-on rise zeroes counter; fall stops and keeps value.
// RQ23: Compare P vs counter bits 9..7; 000 means 1024 clocks.
// RQ24: A flag set on counter equal compare A; sticky until cleared.
// RQ25: Match or overflow clear takes effect on the next clock edge.
module cmt10_timer (
  input wire logic hclk, // System clock, 10 MHz
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [7:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  output logic timer_output_pin, // Timer output pin level
  output logic match_a_flag, // Comparator A sticky flag
  output logic match_p_flag // Comparator P sticky flag
);
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [9:0] compare_a_value_r;
  logic [9:0] count_r;
  logic on_d_r;
  logic pin_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [2:0] hsize_unused;
  logic counter_on;
  logic [2:0] compare_p_value;
  logic [1:0] mode_sel;
  logic [1:0] pin_act;
  logic output_initial_level;
  logic output_invert;
  logic duty_period_swap;
  logic clear_source_select;
  logic on_rise;
  logic match_a;
  logic match_p;
  logic overflow;
  logic clear_cnt;
  logic pulse_stop;
  logic pwm_active;
  logic [10:0] period_len;
  logic [10:0] duty_len;
  logic pin_nxt;
  logic addr_ok;
  logic clr_a_req;
  logic clr_p_req;
  logic [31:0] rdata_nxt;

  assign hsize_unused = hsize;
  assign counter_on = ctrl0_r[cmt10_pkg::CTRL0_ON_BIT];
  assign compare_p_value = ctrl0_r[cmt10_pkg::CTRL0_CMPP_LSB +: 3];
  assign mode_sel = ctrl1_r[cmt10_pkg::CTRL1_MODE_LSB +: 2]; // [RQ12] [RQ20]
  assign pin_act = ctrl1_r[cmt10_pkg::CTRL1_ACT_LSB +: 2];
  assign output_initial_level = ctrl1_r[cmt10_pkg::CTRL1_OIL_BIT];
  assign output_invert = ctrl1_r[cmt10_pkg::CTRL1_INV_BIT];
  assign duty_period_swap = ctrl1_r[cmt10_pkg::CTRL1_SWAP_BIT];
  assign clear_source_select = ctrl1_r[cmt10_pkg::CTRL1_CLR_BIT];
  assign on_rise = counter_on & ~on_d_r;

  // Comparators; A match never fires for a zero compare value
  assign match_a = counter_on && (compare_a_value_r != 10'h000)
    && (count_r == compare_a_value_r); // [RQ16] [RQ24]
  // Zero compare P matches at the top count, giving a 1024 clock period
  assign match_p = counter_on && ((compare_p_value == 3'h0) ? (count_r == cmt10_pkg::CNT_MAX)
    : (count_r == {compare_p_value, 7'h00})); // [RQ23]
  assign overflow = counter_on && (count_r == cmt10_pkg::CNT_MAX);

  // Period and duty lengths in timer clocks, zero P meaning 1024
  always_comb begin
    logic [10:0] p_len;
    logic [10:0] a_len;
    p_len = (compare_p_value == 3'h0) ? 11'h400 : {1'b0, compare_p_value, 7'h00}; // [RQ23]
    a_len = {1'b0, compare_a_value_r};
    if (duty_period_swap) begin // [RQ6]
      period_len = a_len;
      duty_len = p_len;
    end else begin
      period_len = p_len;
      duty_len = a_len;
    end
  end

  // Counter clear source per mode
  always_comb begin
    clear_cnt = 1'b0;
    pulse_stop = 1'b0;
    case (mode_sel)
      cmt10_pkg::MODE_CMP, cmt10_pkg::MODE_TMR: begin
        if (clear_source_select) begin
          clear_cnt = match_a; // [RQ7]
        end else begin
          clear_cnt = match_p || (overflow && compare_p_value == 3'h0); // [RQ7] [RQ8]
        end
      end
      cmt10_pkg::MODE_CAP: begin
        clear_cnt = match_p || overflow; // [RQ9]
      end
      default: begin
        if (pin_act == cmt10_pkg::PWM_PULSE) begin
          pulse_stop = match_a; // [RQ9]
        end else begin
          clear_cnt = counter_on && ({1'b0, count_r} == period_len - 11'h001); // [RQ6] [RQ9]
        end
      end
    endcase
  end

  assign pwm_active = ({1'b0, count_r} < duty_len);

  // Counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= 10'h000;
    end else if (on_rise) begin
      count_r <= 10'h000; // [RQ22]
    end else if (counter_on && !pulse_stop) begin
      if (clear_cnt) begin
        count_r <= 10'h000; // [RQ25]
      end else begin
        count_r <= count_r + 10'h001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_d_r <= 1'b0;
    end else begin
      on_d_r <= counter_on;
    end
  end

  // Internal pin level before inversion
  always_comb begin
    pin_nxt = pin_r;
    case (mode_sel)
      cmt10_pkg::MODE_CMP: begin
        if (on_rise) begin
          pin_nxt = output_initial_level; // [RQ1] [RQ19]
        end else if (match_a) begin // [RQ17]
          case (pin_act) // [RQ18] [RQ21]
            cmt10_pkg::ACT_LOW: pin_nxt = 1'b0;
            cmt10_pkg::ACT_HIGH: pin_nxt = 1'b1;
            cmt10_pkg::ACT_TOG: pin_nxt = ~pin_r;
            default: pin_nxt = pin_r;
          endcase
        end
      end
      cmt10_pkg::MODE_PWM: begin
        case (pin_act) // [RQ2]
          cmt10_pkg::PWM_INACT: pin_nxt = ~output_initial_level;
          cmt10_pkg::PWM_ACT: pin_nxt = output_initial_level;
          cmt10_pkg::PWM_RUN: begin
            pin_nxt = pwm_active ? output_initial_level : ~output_initial_level;
          end
          default: begin
            if (on_rise) begin
              pin_nxt = output_initial_level; // [RQ3]
            end else if (!counter_on || match_a) begin
              pin_nxt = ~output_initial_level;
            end
          end
        endcase
      end
      default: pin_nxt = 1'b0; // [RQ5]
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // Inversion applied only where the pin is used
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_output_pin <= 1'b0;
    end else if (mode_sel == cmt10_pkg::MODE_TMR || mode_sel == cmt10_pkg::MODE_CAP) begin
      timer_output_pin <= 1'b0; // [RQ5]
    end else begin
      timer_output_pin <= pin_nxt ^ output_invert; // [RQ4]
    end
  end

  // Bus address phase capture
  assign addr_ok = hsel && hready && (htrans == cmt10_pkg::HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr;
    end
  end

  assign clr_a_req = wr_pend_r && wr_addr_r == cmt10_pkg::ADDR_FLAGS
    && hwdata[cmt10_pkg::FLAG_A_BIT];
  assign clr_p_req = wr_pend_r && wr_addr_r == cmt10_pkg::ADDR_FLAGS
    && hwdata[cmt10_pkg::FLAG_P_BIT];

  // Control and compare registers; pulse mode A match drops counter-on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0_r <= cmt10_pkg::CTRL0_RST;
      ctrl1_r <= cmt10_pkg::CTRL1_RST;
      compare_a_value_r <= cmt10_pkg::CMPA_RST;
    end else begin
      if (wr_pend_r && wr_addr_r == cmt10_pkg::ADDR_CTRL0) begin
        ctrl0_r <= hwdata[7:0];
      end else if (pulse_stop) begin
        ctrl0_r[cmt10_pkg::CTRL0_ON_BIT] <= 1'b0;
      end
      if (wr_pend_r && wr_addr_r == cmt10_pkg::ADDR_CTRL1) begin
        ctrl1_r <= hwdata[7:0];
      end
      if (wr_pend_r && wr_addr_r == cmt10_pkg::ADDR_CMPA_LO) begin
        compare_a_value_r[7:0] <= hwdata[7:0]; // [RQ11]
      end
      if (wr_pend_r && wr_addr_r == cmt10_pkg::ADDR_CMPA_HI) begin
        compare_a_value_r[9:8] <= hwdata[1:0]; // [RQ11]
      end
    end
  end

  // Sticky flags; a new match wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_a_flag <= 1'b0;
    end else if (match_a) begin
      match_a_flag <= 1'b1; // [RQ24] [RQ13] [RQ14]
    end else if (clr_a_req) begin
      match_a_flag <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_p_flag <= 1'b0;
    end else if (match_p && !((mode_sel == cmt10_pkg::MODE_CMP
        || mode_sel == cmt10_pkg::MODE_TMR) && clear_source_select)) begin
      match_p_flag <= 1'b1; // [RQ13] [RQ14]
    end else if (clr_p_req) begin
      match_p_flag <= 1'b0;
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (haddr == cmt10_pkg::ADDR_CTRL0) begin
      rdata_nxt[7:0] = ctrl0_r;
    end else if (haddr == cmt10_pkg::ADDR_CTRL1) begin
      rdata_nxt[7:0] = ctrl1_r;
    end else if (haddr == cmt10_pkg::ADDR_CNT_LO) begin
      rdata_nxt[7:0] = count_r[7:0]; // [RQ10]
    end else if (haddr == cmt10_pkg::ADDR_CNT_HI) begin
      rdata_nxt[1:0] = count_r[9:8]; // [RQ10]
    end else if (haddr == cmt10_pkg::ADDR_CMPA_LO) begin
      rdata_nxt[7:0] = compare_a_value_r[7:0];
    end else if (haddr == cmt10_pkg::ADDR_CMPA_HI) begin
      rdata_nxt[1:0] = compare_a_value_r[9:8];
    end else if (haddr == cmt10_pkg::ADDR_FLAGS) begin
      rdata_nxt[cmt10_pkg::FLAG_A_BIT] = match_a_flag;
      rdata_nxt[cmt10_pkg::FLAG_P_BIT] = match_p_flag;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rdata_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule : cmt10_timer

// [compare_match_timer_10bit_test.sv]
// Self-checking bench of the 10-bit compare match timer
`timescale 1ns/100ps
module compare_match_timer_10bit_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, pin, fa, fp;
  logic [31:0] hrdata, rd;
  logic [15:0] edges, e0;
  logic [9:0] c1, c2;
  // Rows: action, initial level, invert, pin after A match
  logic [4:0] rows [6] = '{5'h05, 5'h0C, 5'h11, 5'h1A, 5'h12, 5'h0F};
  int num_errors = 0;
  int samples_checked = 0;
  always #50 hclk = ~hclk;
  assign hready = hreadyout;
  cmt10_timer i_cmt10_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_output_pin(pin),
    .match_a_flag(fa), .match_p_flag(fp));
  cmt10_load i_cmt10_load (.hclk(hclk), .hresetn(hresetn), .timer_output_pin(pin),
    .edge_count(edges));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    htrans <= cmt10_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 50) begin num_errors++; results(); end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic wait_flag(input logic p, input int lim);
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while ((p ? fp : fa) !== 1'b1 && n < lim);
    if (n >= lim) begin num_errors++; results(); end
  endtask : wait_flag
  task automatic rd_cnt(output logic [9:0] c);
    xfer(1'b0, cmt10_pkg::ADDR_CNT_LO, 32'h0);
    c[7:0] = rd[7:0];
    xfer(1'b0, cmt10_pkg::ADDR_CNT_HI, 32'h0);
    c[9:8] = rd[1:0];
  endtask : rd_cnt
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, 8'(i * 4), 32'h0);
      check(rd, 32'h0);
      check(32'({hreadyout, hresp}), 32'h2);
    end
    check(32'({pin, fa, fp}), 32'h0);
    $display("test reset done");
    wr(cmt10_pkg::ADDR_CMPA_LO, 32'hC8);
    foreach (rows[i]) begin
      wr(cmt10_pkg::ADDR_CTRL0, 32'h01);
      wr(cmt10_pkg::ADDR_FLAGS, 32'h3);
      wr(cmt10_pkg::ADDR_CTRL1, {24'h0, cmt10_pkg::MODE_CMP, rows[i][4:1], 2'b01});
      wr(cmt10_pkg::ADDR_CTRL0, 32'h09);
      repeat (2) @(posedge hclk);
      check(32'(pin), 32'(rows[i][2] ^ rows[i][1]));
      wait_flag(1'b0, 400);
      check(32'({pin, fp}), 32'({rows[i][0], 1'b0}));
      $display("test row %0d done", i);
    end
    wr(cmt10_pkg::ADDR_CTRL0, 32'h01);
    wr(cmt10_pkg::ADDR_FLAGS, 32'h3);
    wr(cmt10_pkg::ADDR_CTRL1, 32'h00);
    wr(cmt10_pkg::ADDR_CMPA_LO, 32'h40);
    wr(cmt10_pkg::ADDR_CTRL0, 32'h09);
    wait_flag(1'b1, 300);
    repeat (100) @(posedge hclk);
    wr(cmt10_pkg::ADDR_CTRL0, 32'h01);
    check(32'({fa, fp}), 32'h3);
    rd_cnt(c1);
    repeat (5) @(posedge hclk);
    rd_cnt(c2);
    check(32'(c2), 32'(c1));
    check(32'(c1 >= 10'd128), 32'h0);
    wr(cmt10_pkg::ADDR_FLAGS, 32'h3);
    @(posedge hclk);
    check(32'({fa, fp}), 32'h0);
    wr(cmt10_pkg::ADDR_CNT_LO, 32'hFF);
    rd_cnt(c2);
    check(32'(c2), 32'(c1));
    wr(cmt10_pkg::ADDR_CMPA_LO, 32'hFFFF_FFAB);
    wr(cmt10_pkg::ADDR_CMPA_HI, 32'hFFFF_FFFF);
    xfer(1'b0, cmt10_pkg::ADDR_CMPA_LO, 32'h0);
    check(rd, 32'hAB);
    xfer(1'b0, cmt10_pkg::ADDR_CMPA_HI, 32'h0);
    check(rd, 32'h3);
    wr(cmt10_pkg::ADDR_CTRL0, 32'h09);
    wr(cmt10_pkg::ADDR_CTRL0, 32'h01);
    rd_cnt(c2);
    check(32'(c2 > 10'd3), 32'h0);
    $display("test clear on P done");
    // Timer mode set before compare A goes to zero
    wr(cmt10_pkg::ADDR_CTRL1, 32'hCC);
    wr(cmt10_pkg::ADDR_CMPA_LO, 32'h0);
    wr(cmt10_pkg::ADDR_CMPA_HI, 32'h0);
    wr(cmt10_pkg::ADDR_FLAGS, 32'h3);
    e0 = edges;
    wr(cmt10_pkg::ADDR_CTRL0, 32'h08);
    wait_flag(1'b1, 1100);
    wr(cmt10_pkg::ADDR_CTRL0, 32'h00);
    rd_cnt(c2);
    check(32'(c2 > 10'd8), 32'h0);
    check(32'({fa, pin}), 32'h0);
    check(32'(edges), 32'(e0));
    $display("test timer mode done");
    wr(cmt10_pkg::ADDR_CTRL1, 32'h98);
    repeat (2) @(posedge hclk);
    check(32'(pin), 32'h1);
    wr(cmt10_pkg::ADDR_CMPA_LO, 32'h20);
    wr(cmt10_pkg::ADDR_CTRL1, 32'hB8);
    wr(cmt10_pkg::ADDR_CTRL0, 32'h08);
    repeat (2) @(posedge hclk);
    check(32'(pin), 32'h1);
    wait_flag(1'b0, 100);
    repeat (2) @(posedge hclk);
    check(32'(pin), 32'h0);
    xfer(1'b0, cmt10_pkg::ADDR_CTRL0, 32'h0);
    check(rd, 32'h0);
    $display("test pwm and pulse done");
    results();
  end
endmodule : compare_match_timer_10bit_test
